/* File: sme_pkg.sv */
// Package for the serial master/slave block with its silicon anomalies.
// Assumes a single 100 MHz clock domain and a synchronous active-high reset.
package sme_pkg;
  localparam int unsigned WORD_W          = 8;
  localparam int unsigned DIV_W           = 8;
  localparam int unsigned NUM_CS          = 2;
  localparam int unsigned CS_W            = 1;
  localparam int unsigned BIT_CNT_W       = 4;
  localparam logic [DIV_W-1:0]   DIV_ONE        = 8'h01;
  localparam logic [WORD_W-1:0]  WORD_RST       = 8'h00;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_WORD = 4'h8;
  localparam logic [BIT_CNT_W-1:0] CNT_ZERO     = 4'h0;
  localparam logic [DIV_W-1:0]   DIV_ZERO       = 8'h00;

  typedef struct packed {
    logic             enable;
    logic             master_mode;
    logic             fault_detect_disable;
    logic             clk_pol;
    logic             inverted_phase_bit;
  } sme_cfg_t;

  typedef struct packed {
    logic [DIV_W-1:0] serial_clock_divider;
    logic             hold_select_after_transfer;
  } sme_cs_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_EXTRA = 3'b100
  } sme_state_t;

  function automatic logic sme_div_is_one(input logic [DIV_W-1:0] d);
    return d == DIV_ONE;
  endfunction
endpackage

/* File: sme_dma_hs.sv */
// Peripheral DMA handshake for the transmit side.
// Assumes tx_empty and error come from logic on the same clock.
`timescale 1ns/1ps
module sme_dma_hs (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic dma_ch_en,
  input  wire logic tx_empty,
  input  wire logic xfer_error,
  input  wire logic periph_enable,
  output logic      dma_tx_req_reg,
  output logic      stalled_reg
);
  logic en_d_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= periph_enable;
    end
  end

  // Only a disable then enable of the peripheral frees the stall
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stalled_reg <= 1'b0;
    end else if (xfer_error) begin
      stalled_reg <= 1'b1;
    end else if (periph_enable && !en_d_reg) begin
      stalled_reg <= 1'b0;
    end
  end

  // Request follows the empty flag, not the enable
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dma_tx_req_reg <= 1'b0;
    end else begin
      dma_tx_req_reg <= dma_ch_en && tx_empty && !stalled_reg && !xfer_error;
    end
  end

  chk_stall_blocks: assert property (@(posedge sys_clk) disable iff (srst)
    stalled_reg |=> !dma_tx_req_reg) else $error("request while stalled");
endmodule

/* File: sme_core.sv */
// Serial master/slave core with its silicon anomalies preserved.
// Assumes serial pins are synchronised here; DMA and config on sys_clk.
`timescale 1ns/1ps
module sme_core
  import sme_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire logic                        soft_reset,
  input  wire sme_pkg::sme_cfg_t           cfg,
  input  wire sme_pkg::sme_cs_cfg_t [1:0]  cs_cfg,
  input  wire logic [sme_pkg::CS_W-1:0]    cs_sel,
  input  wire logic                        tx_wr,
  input  wire logic [sme_pkg::WORD_W-1:0]  tx_data,
  input  wire logic                        rx_rd,
  input  wire logic                        dma_ch_en,
  input  wire logic                        dma_xfer_error,
  input  wire logic                        miso_in,
  input  wire logic                        sclk_in,
  input  wire logic                        ss_n_in,
  output logic                             sclk_out_reg,
  output logic                             mosi_out_reg,
  output logic [1:0]                       cs_n_reg,
  output logic                             tx_holding_empty_flag,
  output logic [sme_pkg::WORD_W-1:0]       rx_data_reg,
  output logic                             rx_full_reg,
  output logic                             active_reg,
  output logic                             dma_tx_req,
  output logic                             dma_stalled
);
  import sme_pkg::*;

  sme_state_t           state_reg;
  logic                 run_reg;
  logic                 empty_reg;
  logic [WORD_W-1:0]    tx_holding_reg;
  logic [WORD_W-1:0]    shift_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [DIV_W-1:0]     div_cnt_reg;
  logic [2:0]           sclk_sync_reg;
  logic [1:0]           ss_sync_reg;
  logic [1:0]           miso_sync_reg;
  logic                 hang;
  logic                 mixed_div;
  logic                 slave_edge;
  logic [DIV_W-1:0]     cur_div;
  logic                 ss_prev_reg;
  logic                 ss_fall;
  logic                 start_word;

  // Pin synchronisers; only the second stage and later are read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sclk_sync_reg <= 3'h0;
      ss_sync_reg   <= 2'h3;
      ss_prev_reg   <= 1'b1;
      miso_sync_reg <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
      ss_sync_reg   <= {ss_sync_reg[0], ss_n_in};
      ss_prev_reg   <= ss_sync_reg[1];
      miso_sync_reg <= {miso_sync_reg[0], miso_in};
    end
  end

  assign hang       = cs_cfg[0].hold_select_after_transfer && !cfg.fault_detect_disable;
  assign mixed_div  = sme_div_is_one(cs_cfg[0].serial_clock_divider) != sme_div_is_one(cs_cfg[1].serial_clock_divider);
  assign cur_div    = cs_cfg[cs_sel].serial_clock_divider;
  assign slave_edge = !ss_sync_reg[1] && sclk_sync_reg[1] && !sclk_sync_reg[2];
  // Slave takes one word per select fall; longer frames are not supported
  assign ss_fall    = !ss_sync_reg[1] && ss_prev_reg;
  assign start_word = state_reg == ST_IDLE && run_reg && !hang && (cfg.master_mode ? !empty_reg : ss_fall);

  // Enable state; a slave ignores disable, only soft reset stops it
  always_ff @(posedge sys_clk) begin
    if (srst || soft_reset) begin
      run_reg <= 1'b0;
    end else if (cfg.enable) begin
      run_reg <= 1'b1;
    end else if (cfg.master_mode) begin
      run_reg <= 1'b0;
    end
  end

  // Holding register and empty flag; set wins over the clearing write
  always_ff @(posedge sys_clk) begin
    if (srst || soft_reset) begin
      empty_reg      <= 1'b1;
      tx_holding_reg <= WORD_RST;
    end else if (!empty_reg && start_word) begin
      empty_reg <= 1'b1;
    end else if (tx_wr && run_reg) begin
      empty_reg      <= 1'b0;
      tx_holding_reg <= tx_data;
    end
  end
  // Writes while disabled fall through untouched above: flag unchanged, data dropped
  assign tx_holding_empty_flag = empty_reg;

  // Shift engine
  always_ff @(posedge sys_clk) begin
    if (srst || soft_reset) begin
      state_reg    <= ST_IDLE;
      shift_reg    <= WORD_RST;
      bit_cnt_reg  <= CNT_ZERO;
      div_cnt_reg  <= DIV_ZERO;
      sclk_out_reg <= 1'b0;
      mosi_out_reg <= 1'b0;
      cs_n_reg     <= 2'h3;
      active_reg   <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sclk_out_reg <= cfg.clk_pol;
          if (start_word) begin
            state_reg    <= ST_SHIFT;
            shift_reg    <= tx_holding_reg;
            mosi_out_reg <= tx_holding_reg[WORD_W-1];
            bit_cnt_reg <= CNT_ZERO;
            div_cnt_reg <= cur_div;
            active_reg  <= 1'b1;
            if (cfg.master_mode) begin
              cs_n_reg[cs_sel] <= 1'b0;
            end
          end
        end
        ST_SHIFT: begin
          if (cfg.master_mode) begin
            if (div_cnt_reg > DIV_ONE) begin
              div_cnt_reg <= div_cnt_reg - DIV_ONE;
            end else begin
              div_cnt_reg  <= cur_div;
              sclk_out_reg <= !sclk_out_reg;
              if (sclk_out_reg != cfg.clk_pol) begin
                // Next bit ready well before the next leading edge
                mosi_out_reg <= shift_reg[WORD_W-2];
                shift_reg    <= {shift_reg[WORD_W-2:0], miso_sync_reg[1]};
                bit_cnt_reg  <= bit_cnt_reg + 4'h1;
              end
            end
          end else if (ss_sync_reg[1]) begin
            // Select dropped mid-word: frame abandoned
            state_reg  <= ST_IDLE;
            active_reg <= 1'b0;
          end else if (slave_edge) begin
            mosi_out_reg <= shift_reg[WORD_W-1];
            shift_reg    <= {shift_reg[WORD_W-2:0], miso_sync_reg[1]};
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
          end
          if (bit_cnt_reg == BITS_PER_WORD) begin
            // Anomalous mode: one more clock toggle pair follows
            if (cfg.master_mode && cfg.clk_pol && !cfg.inverted_phase_bit && mixed_div) begin
              state_reg    <= ST_EXTRA;
              sclk_out_reg <= !cfg.clk_pol;
            end else begin
              // Overrides a divider-1 toggle in this cycle
              sclk_out_reg <= cfg.clk_pol;
              state_reg  <= ST_IDLE;
              active_reg <= 1'b0;
              if (!cs_cfg[cs_sel].hold_select_after_transfer) begin
                cs_n_reg <= 2'h3;
              end
            end
          end
        end
        ST_EXTRA: begin
          sclk_out_reg <= cfg.clk_pol;
          state_reg    <= ST_IDLE;
          active_reg   <= 1'b0;
          if (!cs_cfg[cs_sel].hold_select_after_transfer) begin
            cs_n_reg <= 2'h3;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive word; new data wins over a same-cycle read
  always_ff @(posedge sys_clk) begin
    if (srst || soft_reset) begin
      rx_data_reg <= WORD_RST;
      rx_full_reg <= 1'b0;
    end else if (state_reg == ST_SHIFT && bit_cnt_reg == BITS_PER_WORD) begin
      rx_data_reg <= shift_reg;
      rx_full_reg <= 1'b1;
    end else if (rx_rd) begin
      rx_full_reg <= 1'b0;
    end
  end

  sme_dma_hs u_dma_hs (
    .sys_clk        (sys_clk),
    .srst           (srst),
    .dma_ch_en      (dma_ch_en),
    .tx_empty       (empty_reg),
    .xfer_error     (dma_xfer_error),
    .periph_enable  (cfg.enable),
    .dma_tx_req_reg (dma_tx_req),
    .stalled_reg    (dma_stalled)
  );

  chk_slave_no_stop: assert property (@(posedge sys_clk) disable iff (srst)
    run_reg && !cfg.master_mode && !soft_reset |=> run_reg) else $error("slave stopped by disable");
  chk_hang_no_start: assert property (@(posedge sys_clk) disable iff (srst)
    hang && state_reg == ST_IDLE |=> state_reg == ST_IDLE) else $error("transfer began in hang mode");
  chk_disabled_flag: assert property (@(posedge sys_clk) disable iff (srst)
    !run_reg && !soft_reset && state_reg == ST_IDLE && $stable(empty_reg) |=> $stable(empty_reg) || empty_reg)
    else $error("empty flag changed while disabled");
  chk_write_clears: assert property (@(posedge sys_clk) disable iff (srst)
    tx_wr && run_reg && empty_reg && !soft_reset |=> !empty_reg) else $error("write did not clear empty");
  chk_extra_pulse: assert property (@(posedge sys_clk) disable iff (srst)
    state_reg == ST_EXTRA |-> !sclk_out_reg ##1 sclk_out_reg) else $error("extra pulse shape wrong");
  chk_req_after_off: assert property (@(posedge sys_clk) disable iff (srst)
    dma_ch_en && empty_reg && !dma_stalled && !dma_xfer_error && !cfg.enable |=> dma_tx_req)
    else $error("request dropped on disable");
  chk_error_stall: assert property (@(posedge sys_clk) disable iff (srst)
    dma_xfer_error |=> dma_stalled) else $error("error did not stall");
  chk_empty_reset: assert property (@(posedge sys_clk)
    srst |=> empty_reg) else $error("empty not set after reset");

  cov_master_word: cover property (@(posedge sys_clk) disable iff (srst)
    cfg.master_mode && state_reg == ST_SHIFT ##[1:300] state_reg == ST_IDLE);
  cov_extra: cover property (@(posedge sys_clk) disable iff (srst) state_reg == ST_EXTRA);
  cov_stall: cover property (@(posedge sys_clk) disable iff (srst) dma_stalled ##1 !dma_stalled);
  cov_slave_rx: cover property (@(posedge sys_clk) disable iff (srst) !cfg.master_mode && rx_full_reg);
endmodule

/* File: sme_far_end.sv */
// Far-end serial device: a select-driven slave, and a slow master for slave-mode tests.
// Assumes mode 0 framing and a bench that supplies the reply byte before each frame.
`timescale 1ns/1ps
module sme_far_end (
  input  wire logic       sys_clk,
  input  wire logic       sclk,
  input  wire logic [1:0] cs_n,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic            sclk_m,
  output logic            ss_n_m,
  input  wire logic       mosi,
  output logic [7:0]      seen
);
  logic [7:0] sh;
  initial begin
    seen = 8'h00;
    miso = 1'b0;
    sclk_m = 1'b0;
    ss_n_m = 1'b1;
    sh = 8'h00;
  end
  // Load on select, MSB first, shift on the trailing edge
  always @(negedge (&cs_n)) begin
    sh = reply;
    miso = sh[7];
  end
  always @(negedge sclk) if (!(&cs_n)) begin
    sh = {sh[6:0], ~sh[7]};
    miso = sh[7];
  end
  // Master data taken on the leading edge while selected
  always @(posedge sclk) if (!(&cs_n)) begin
    seen = {seen[6:0], mosi};
  end
  // Released line: flip it so a stale bit is never read as data
  always @(posedge (&cs_n)) miso = ~miso;
  // Slow clock so three sync flops inside see every edge; stands still between frames
  task automatic send_byte(input logic [7:0] b);
    ss_n_m = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      miso = b[i];
      repeat (8) @(posedge sys_clk);
      #1 sclk_m = 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 sclk_m = 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    #1 ss_n_m = 1'b1;
    miso = ~miso;
  endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the serial core: transfers, anomalies, DMA handshake.
// Assumes the far-end model above; queue model holds expected received words.
`timescale 1ns/1ps
module testbench;
  import sme_pkg::*;
  logic                         sys_clk, srst, soft_reset, tx_wr, rx_rd, dma_ch_en, dma_xfer_error;
  sme_pkg::sme_cfg_t            cfg;
  sme_pkg::sme_cs_cfg_t [1:0]   cs_cfg;
  logic [sme_pkg::CS_W-1:0]     cs_sel;
  logic [7:0]                   tx_data, reply, rx_data_reg, seen;
  logic                         miso, sclk_m, ss_n_m, sclk_out_reg, mosi_out_reg, sclk_d;
  logic [1:0]                   cs_n_reg;
  logic                         tx_holding_empty_flag, rx_full_reg, active_reg, dma_tx_req, dma_stalled;
  int                           miscompares, n_tests, pulses, cyc_cnt;
  int                           exp_q[$];

  sme_core uut (.sys_clk(sys_clk), .srst(srst), .soft_reset(soft_reset), .cfg(cfg), .cs_cfg(cs_cfg),
    .cs_sel(cs_sel), .tx_wr(tx_wr), .tx_data(tx_data), .rx_rd(rx_rd), .dma_ch_en(dma_ch_en),
    .dma_xfer_error(dma_xfer_error), .miso_in(miso), .sclk_in(sclk_m), .ss_n_in(ss_n_m),
    .sclk_out_reg(sclk_out_reg), .mosi_out_reg(mosi_out_reg), .cs_n_reg(cs_n_reg),
    .tx_holding_empty_flag(tx_holding_empty_flag), .rx_data_reg(rx_data_reg), .rx_full_reg(rx_full_reg),
    .active_reg(active_reg), .dma_tx_req(dma_tx_req), .dma_stalled(dma_stalled));
  sme_far_end ptn (.sys_clk(sys_clk), .sclk(sclk_out_reg), .cs_n(cs_n_reg), .reply(reply), .miso(miso),
    .sclk_m(sclk_m), .ss_n_m(ss_n_m), .mosi(mosi_out_reg), .seen(seen));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Rising serial clock edges seen by the far end
  always @(posedge sys_clk) begin
    if (sclk_out_reg && !sclk_d) pulses++;
    sclk_d <= sclk_out_reg;
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic wait_rx();
    for (int i = 0; i < 3000 && rx_full_reg !== 1'b1; i++) cyc(1);
  endtask
  // One master word; pulse count and optionally the received word are checked
  task automatic xfer(input logic s, input int n_exp, input bit cmp);
    logic [7:0] r;
    r = 8'($urandom);
    reply = r;
    exp_q.push_back(r);
    cs_sel = s;
    tx_data = 8'($urandom);
    pulses = 0;
    pulse(tx_wr);
    chk(tx_holding_empty_flag, 8'h00, "empty flag not cleared by write");
    wait_rx();
    cyc(12);
    chk(8'(pulses), 8'(n_exp), "serial clock pulse count");
    r = 8'(exp_q.pop_front());
    if (cmp) chk(rx_data_reg, r, "received word");
    if (cmp) chk(seen, tx_data, "sent word");
    pulse(rx_rd);
  endtask

  initial begin
    {soft_reset, tx_wr, rx_rd, dma_ch_en, dma_xfer_error, cs_sel} = '0;
    cfg = '0;
    cs_cfg = '0;
    tx_data = 8'h00;
    reply = 8'h00;
    sclk_d = 1'b0;
    srst = 1'b1;
    void'($urandom(15));
    cyc(3);
    srst = 1'b0;
    chk(tx_holding_empty_flag, 8'h01, "empty flag after reset");
    chk(cs_n_reg, 8'h03, "selects after reset");
    cfg = '{enable: 1'b1, master_mode: 1'b1, fault_detect_disable: 1'b1, clk_pol: 1'b0, inverted_phase_bit: 1'b1};
    cs_cfg[0] = '{serial_clock_divider: 8'h04, hold_select_after_transfer: 1'b0};
    cs_cfg[1] = cs_cfg[0];
    cyc(4);
    for (int i = 0; i < 4; i++) xfer(i[0], 8, 1'b1);
    cfg.clk_pol = 1'b1;
    cfg.inverted_phase_bit = 1'b0;
    cs_cfg[0].serial_clock_divider = 8'h01;
    cyc(10);
    xfer(1'b1, 9, 1'b0);
    cs_cfg[1].serial_clock_divider = 8'h01;
    cyc(10);
    xfer(1'b1, 8, 1'b0);
    cfg = '{enable: 1'b1, master_mode: 1'b1, fault_detect_disable: 1'b0, clk_pol: 1'b0, inverted_phase_bit: 1'b1};
    cs_cfg[0] = '{serial_clock_divider: 8'h04, hold_select_after_transfer: 1'b1};
    cs_sel = 1'b0;
    cyc(4);
    pulse(tx_wr);
    cyc(60);
    chk(active_reg, 8'h00, "transfer started despite hang");
    chk(cs_n_reg, 8'h03, "select driven during hang");
    cfg.enable = 1'b0;
    cyc(3);
    chk(tx_holding_empty_flag, 8'h00, "empty flag moved by disable");
    pulse(soft_reset);
    cfg.fault_detect_disable = 1'b1;
    cfg.enable = 1'b0;
    cyc(3);
    pulse(tx_wr);
    cyc(4);
    chk(tx_holding_empty_flag, 8'h01, "empty flag moved while disabled");
    chk(active_reg, 8'h00, "disabled write started a word");
    dma_ch_en = 1'b1;
    cyc(3);
    chk(dma_tx_req, 8'h01, "request dropped while disabled");
    pulse(dma_xfer_error);
    cyc(3);
    chk(dma_stalled, 8'h01, "no stall after error");
    chk(dma_tx_req, 8'h00, "request after error");
    cfg.enable = 1'b1;
    cyc(3);
    chk(dma_stalled, 8'h00, "stall not cleared by enable");
    chk(dma_tx_req, 8'h01, "request not resumed");
    dma_ch_en = 1'b0;
    cyc(2);
    cfg.master_mode = 1'b0;
    cyc(4);
    cfg.enable = 1'b0;
    exp_q.push_back(int'($urandom) & 255);
    ptn.send_byte(8'(exp_q[0]));
    wait_rx();
    chk(rx_full_reg, 8'h01, "slave stopped by disable");
    chk(rx_data_reg, 8'(exp_q.pop_front()), "slave word");
    pulse(rx_rd);
    pulse(soft_reset);
    cyc(2);
    chk(active_reg, 8'h00, "slave still active after soft reset");
    summarize();
  end
endmodule
